// File: rtl/pmic_clock_generation.sv
`timescale 1ns/1ps
module pmic_clock_generation #(
  parameter int LOSS_CYCLES = clock_generation_pkg::XTAL_LOSS_CYCLES,
  parameter int GOOD_EDGES = clock_generation_pkg::XTAL_GOOD_EDGES
) (
  // clock and resets
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic coin_cell_power_on_reset_n,
  // register access
  input wire clock_generation_pkg::reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // oscillator pins
  input wire logic xtal_clock_pin,
  input wire logic rc_clock_pin,
  // on-chip requests
  input wire logic startup_driver_enable,
  input wire logic block_clock_request,
  // status pins
  input wire logic companion_rail,
  input wire logic factory_test_select_pin,
  // loop control
  output logic [2:0] feedback_ratio_select,
  output logic [7:0] pll_feedback_ratio,
  output logic pll_enable,
  output logic sixteen_meg_output_enable,
  // slow clock output
  output logic slow_clock_output,
  output logic slow_clock_output_enable,
  output logic [1:0] slow_clock_drive_strength,
  output logic backup_source_active,
  output logic second_tick,
  // audio clock output
  output logic audio_clock_output_enable,
  output logic [1:0] audio_clock_drive_strength,
  // protection
  output logic thermal_protection_enable,
  output logic fuse_program_block
);

  function automatic logic [7:0] ratio_of(input logic [2:0] code);
    ratio_of = clock_generation_pkg::RATIO_BASE + {3'b000, code, 2'b00};
  endfunction

  function automatic logic [15:0] tick_last(input logic [7:0] cal);
    tick_last = clock_generation_pkg::TICK_NOMINAL_LAST + {{8{cal[7]}}, cal};
  endfunction

  logic [7:0] pll_ctrl_reg;
  logic [7:0] pll_ctrl_next;
  logic [7:0] drive_two_reg;
  logic [7:0] drive_two_next;
  logic [7:0] tick_cal_reg;
  logic [7:0] tick_cal_next;
  logic driver_disable_reg;
  logic driver_disable_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic [15:0] tick_count_reg;
  logic [15:0] tick_count_next;
  logic tick_reg;
  logic [1:0] coin_sync_reg;
  logic [1:0] rail_sync_reg;
  logic [1:0] test_sync_reg;
  logic [2:0] ratio_sel_reg;
  logic [7:0] ratio_reg;
  logic pll_en_reg;
  logic sixteen_reg;
  logic slow_level_reg;
  logic slow_en_reg;
  logic [1:0] slow_drive_reg;
  logic backup_reg;
  logic audio_en_reg;
  logic [1:0] audio_drive_reg;
  logic thermal_en_reg;
  logic fuse_block_reg;
  logic src_level;
  logic src_rise;
  logic src_backup;

  clock_source_switch #(
    .LOSS_CYCLES(LOSS_CYCLES),
    .GOOD_EDGES(GOOD_EDGES)
  ) source_switch (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .xtal_clock_pin(xtal_clock_pin),
    .rc_clock_pin(rc_clock_pin),
    .clock_level(src_level),
    .clock_rise(src_rise),
    .backup_active(src_backup)
  );

  // pins from outside the clock domain
  always_ff @(posedge clk_sys)
  begin
    coin_sync_reg <= {coin_sync_reg[0], coin_cell_power_on_reset_n};
    rail_sync_reg <= {rail_sync_reg[0], companion_rail};
    test_sync_reg <= {test_sync_reg[0], factory_test_select_pin};
  end

  wire coin_reset = ~coin_sync_reg[1];
  wire rail_on = rail_sync_reg[1];
  wire test_mode = test_sync_reg[1];

  // register decode
  wire hit_pll = (reg_req.addr == clock_generation_pkg::PLL_CTRL_OFFSET);
  wire hit_drive = (reg_req.addr == clock_generation_pkg::DRIVE_TWO_OFFSET);
  wire hit_slow = (reg_req.addr == clock_generation_pkg::SLOW_CTRL_OFFSET);
  wire hit_cal = (reg_req.addr == clock_generation_pkg::TICK_CAL_OFFSET);
  wire [7:0] slow_status = {5'b00000, test_mode, src_backup, driver_disable_reg};

  assign pll_ctrl_next = (reg_req.wr && hit_pll) ?
    (reg_req.wdata & clock_generation_pkg::PLL_CTRL_WRITABLE) : pll_ctrl_reg;
  assign drive_two_next = (reg_req.wr && hit_drive) ? reg_req.wdata : drive_two_reg;
  assign tick_cal_next = (reg_req.wr && hit_cal) ? reg_req.wdata : tick_cal_reg;
  assign driver_disable_next = (reg_req.wr && hit_slow) ?
    reg_req.wdata[clock_generation_pkg::DRIVER_DISABLE_BIT] : driver_disable_reg;
  assign rdata_next = !reg_req.rd ? 8'h00 :
    hit_pll ? pll_ctrl_reg :
    hit_drive ? drive_two_reg :
    hit_slow ? slow_status :
    hit_cal ? tick_cal_reg : 8'h00;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pll_ctrl_reg <= clock_generation_pkg::PLL_CTRL_RESET;
      drive_two_reg <= clock_generation_pkg::DRIVE_TWO_RESET;
      tick_cal_reg <= clock_generation_pkg::TICK_CAL_RESET;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      pll_ctrl_reg <= pll_ctrl_next;
      drive_two_reg <= drive_two_next;
      tick_cal_reg <= tick_cal_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= reg_req.rd;
    end
  end

  // kept through system resets, cleared by the coin cell reset or by a write of zero
  always_ff @(posedge clk_sys)
  begin
    if (coin_reset)
      driver_disable_reg <= 1'b0;
    else
      driver_disable_reg <= driver_disable_next;
  end

  // one second divider on the selected slow clock
  wire [15:0] tick_end = tick_last(tick_cal_reg);
  wire tick_wrap = src_rise && (tick_count_reg >= tick_end);
  assign tick_count_next = tick_wrap ? 16'h0000 : (src_rise ? tick_count_reg + 16'h0001 : tick_count_reg);

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      tick_count_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_count_reg <= tick_count_next;
      tick_reg <= tick_wrap;
    end
  end

  // output stage
  wire [2:0] ratio_field = pll_ctrl_reg[clock_generation_pkg::RATIO_LSB +: 3];
  wire sixteen_bit = pll_ctrl_reg[clock_generation_pkg::SIXTEEN_BIT];
  wire forced_bit = pll_ctrl_reg[clock_generation_pkg::FORCED_BIT];
  wire loop_on = forced_bit | sixteen_bit | block_clock_request;
  wire slow_drive_on = startup_driver_enable & ~driver_disable_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      ratio_sel_reg <= 3'h0;
      ratio_reg <= clock_generation_pkg::RATIO_BASE;
      pll_en_reg <= 1'b0;
      sixteen_reg <= 1'b0;
      slow_level_reg <= 1'b0;
      slow_en_reg <= 1'b0;
      slow_drive_reg <= 2'h0;
      backup_reg <= 1'b1;
      audio_en_reg <= 1'b0;
      audio_drive_reg <= 2'h0;
      thermal_en_reg <= 1'b1;
      fuse_block_reg <= 1'b1;
    end
    else
    begin
      ratio_sel_reg <= ratio_field;
      ratio_reg <= ratio_of(ratio_field);
      pll_en_reg <= loop_on;
      sixteen_reg <= sixteen_bit;
      slow_level_reg <= src_level;
      slow_en_reg <= slow_drive_on;
      slow_drive_reg <= drive_two_reg[clock_generation_pkg::SLOW_DRIVE_LSB +: 2];
      backup_reg <= src_backup;
      audio_en_reg <= rail_on;
      audio_drive_reg <= drive_two_reg[clock_generation_pkg::AUDIO_DRIVE_LSB +: 2];
      thermal_en_reg <= ~test_mode;
      fuse_block_reg <= 1'b1;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign feedback_ratio_select = ratio_sel_reg;
  assign pll_feedback_ratio = ratio_reg;
  assign pll_enable = pll_en_reg;
  assign sixteen_meg_output_enable = sixteen_reg;
  assign slow_clock_output = slow_level_reg;
  assign slow_clock_output_enable = slow_en_reg;
  assign slow_clock_drive_strength = slow_drive_reg;
  assign backup_source_active = backup_reg;
  assign second_tick = tick_reg;
  assign audio_clock_output_enable = audio_en_reg;
  assign audio_clock_drive_strength = audio_drive_reg;
  assign thermal_protection_enable = thermal_en_reg;
  assign fuse_program_block = fuse_block_reg;

  sequence s_pll_write;
    reg_req.wr && hit_pll;
  endsequence

  sequence s_stored;
    ##1 1'b1;
  endsequence

  property p_ratio;
    @(posedge clk_sys) disable iff (!resetn)
    s_pll_write ##0 s_stored |=> pll_feedback_ratio == 8'h70 + 8'h04 * {5'b00000, $past(reg_req.wdata[2:0], 2)};
  endproperty
  a_ratio: assert property (p_ratio) else $error("feedback ratio does not follow field");

  property p_sixteen_on;
    @(posedge clk_sys) disable iff (!resetn)
    sixteen_bit |=> (sixteen_meg_output_enable && pll_enable);
  endproperty
  a_sixteen_on: assert property (p_sixteen_on) else $error("sixteen meg set but output or loop off");

  property p_sixteen_off;
    @(posedge clk_sys) disable iff (!resetn)
    !sixteen_bit |=> !sixteen_meg_output_enable;
  endproperty
  a_sixteen_off: assert property (p_sixteen_off) else $error("sixteen meg output on while bit clear");

  property p_loop_demand;
    @(posedge clk_sys) disable iff (!resetn)
    (forced_bit || !block_clock_request && !sixteen_bit) |=> (pll_enable == $past(forced_bit));
  endproperty
  a_loop_demand: assert property (p_loop_demand) else $error("loop enable wrong without requests");

  property p_driver;
    @(posedge clk_sys) disable iff (!resetn)
    1'b1 |=> slow_clock_output_enable == ($past(startup_driver_enable) && !$past(driver_disable_reg));
  endproperty
  a_driver: assert property (p_driver) else $error("slow clock driver enable wrong");

  property p_disable_kept;
    @(posedge clk_sys)
    (!coin_reset && !(reg_req.wr && hit_slow)) |=> $stable(driver_disable_reg);
  endproperty
  a_disable_kept: assert property (p_disable_kept) else $error("driver disable changed without write");

  property p_audio;
    @(posedge clk_sys) disable iff (!resetn)
    !rail_on |=> !audio_clock_output_enable;
  endproperty
  a_audio: assert property (p_audio) else $error("audio clock enabled with rail off");

  property p_drive_fields;
    @(posedge clk_sys) disable iff (!resetn)
    1'b1 |=> (slow_clock_drive_strength == $past(drive_two_reg[1:0]))
      && (audio_clock_drive_strength == $past(drive_two_reg[3:2]));
  endproperty
  a_drive_fields: assert property (p_drive_fields) else $error("drive strength fields misrouted");

  property p_tick_pulse;
    @(posedge clk_sys) disable iff (!resetn)
    second_tick |=> !second_tick && tick_count_reg <= 16'h0001;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("second tick not a single pulse at wrap");

  property p_status_read;
    @(posedge clk_sys) disable iff (!resetn)
    (reg_req.rd && hit_slow) |=> reg_rdata[1] == $past(src_backup);
  endproperty
  a_status_read: assert property (p_status_read) else $error("backup status bit reads wrong");

  property p_fuse;
    @(posedge clk_sys) disable iff (!resetn)
    $past(resetn) |-> fuse_program_block;
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse programming not blocked");

  property p_thermal;
    @(posedge clk_sys) disable iff (!resetn)
    test_mode |=> !thermal_protection_enable;
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal protection on in test mode");

endmodule

// File: rtl/clock_generation_pkg.sv
package clock_generation_pkg;

  // system clock
  localparam int CLK_SYS_KHZ = 20000;

  // register space
  localparam logic [8:0] DRIVE_TWO_OFFSET = 9'h1c0;
  localparam logic [8:0] PLL_CTRL_OFFSET = 9'h1e4;
  localparam logic [8:0] SLOW_CTRL_OFFSET = 9'h1e5;
  localparam logic [8:0] TICK_CAL_OFFSET = 9'h1e6;

  localparam logic [7:0] PLL_CTRL_RESET = 8'h1b;
  localparam logic [7:0] PLL_CTRL_WRITABLE = 8'h1f;
  localparam logic [7:0] DRIVE_TWO_RESET = 8'h04;
  localparam logic [7:0] TICK_CAL_RESET = 8'h00;

  // pll control fields
  localparam int RATIO_LSB = 0;
  localparam int SIXTEEN_BIT = 3;
  localparam int FORCED_BIT = 4;
  localparam logic [7:0] RATIO_BASE = 8'h70;

  // drive control two fields
  localparam int SLOW_DRIVE_LSB = 0;
  localparam int AUDIO_DRIVE_LSB = 2;

  // slow clock control and status fields
  localparam int DRIVER_DISABLE_BIT = 0;
  localparam int BACKUP_ACTIVE_BIT = 1;
  localparam int TEST_MODE_BIT = 2;

  // one second divider
  localparam logic [15:0] TICK_NOMINAL_LAST = 16'h7fff;

  // crystal supervision
  localparam int XTAL_LOSS_TIME_US = 100;
  localparam int XTAL_LOSS_CYCLES = (XTAL_LOSS_TIME_US * CLK_SYS_KHZ) / 1000;
  localparam int XTAL_GOOD_EDGES = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef enum logic [0:0] {
    SRC_CRYSTAL = 1'b0,
    SRC_BACKUP = 1'b1
  } source_type;

endpackage

// File: rtl/clock_source_switch.sv
`timescale 1ns/1ps
module clock_source_switch #(
  parameter int LOSS_CYCLES = clock_generation_pkg::XTAL_LOSS_CYCLES,
  parameter int GOOD_EDGES = clock_generation_pkg::XTAL_GOOD_EDGES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // oscillator pins
  input wire logic xtal_clock_pin,
  input wire logic rc_clock_pin,
  // selected source
  output logic clock_level,
  output logic clock_rise,
  output logic backup_active
);

  logic [2:0] xtal_sync_reg;
  logic [2:0] rc_sync_reg;
  logic [11:0] loss_count_reg;
  logic [11:0] loss_count_next;
  logic [2:0] good_count_reg;
  logic [2:0] good_count_next;
  logic running_reg;
  logic running_next;
  clock_generation_pkg::source_type sel_reg;
  clock_generation_pkg::source_type sel_next;
  logic level_reg;
  logic prev_level_reg;

  wire xtal_s = xtal_sync_reg[1];
  wire rc_s = rc_sync_reg[1];
  wire xtal_rise = xtal_sync_reg[1] & ~xtal_sync_reg[2];
  wire loss_timeout = (loss_count_reg == 12'(LOSS_CYCLES - 1));
  wire both_low = ~xtal_s & ~rc_s;
  wire clock_source_type_want = ~running_reg;

  // crystal counts as running after several edges, lost after a silent window
  assign loss_count_next = xtal_rise ? 12'h000 : (loss_timeout ? loss_count_reg : loss_count_reg + 12'h001);
  assign good_count_next = loss_timeout ? 3'h0 :
    ((xtal_rise && good_count_reg != 3'(GOOD_EDGES)) ? good_count_reg + 3'h1 : good_count_reg);
  assign running_next = (good_count_reg == 3'(GOOD_EDGES)) & ~loss_timeout;
  // source change only while both levels are low
  assign sel_next = (both_low && sel_reg != clock_generation_pkg::source_type'(clock_source_type_want)) ?
    clock_generation_pkg::source_type'(clock_source_type_want) : sel_reg;

  always_ff @(posedge clk_sys)
  begin
    xtal_sync_reg <= {xtal_sync_reg[1:0], xtal_clock_pin};
    rc_sync_reg <= {rc_sync_reg[1:0], rc_clock_pin};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      loss_count_reg <= 12'h000;
      good_count_reg <= 3'h0;
      running_reg <= 1'b0;
      sel_reg <= clock_generation_pkg::SRC_BACKUP;
      level_reg <= 1'b0;
      prev_level_reg <= 1'b0;
    end
    else
    begin
      loss_count_reg <= loss_count_next;
      good_count_reg <= good_count_next;
      running_reg <= running_next;
      sel_reg <= sel_next;
      level_reg <= (sel_reg == clock_generation_pkg::SRC_BACKUP) ? rc_s : xtal_s;
      prev_level_reg <= level_reg;
    end
  end

  assign clock_level = level_reg;
  assign clock_rise = level_reg & ~prev_level_reg;
  assign backup_active = (sel_reg == clock_generation_pkg::SRC_BACKUP);

  property p_switch_low;
    @(posedge clk_sys) disable iff (!resetn)
    (sel_reg != sel_next) |-> both_low;
  endproperty
  a_switch_low: assert property (p_switch_low) else $error("source switched while a clock was high");

  property p_no_backup_when_running;
    @(posedge clk_sys) disable iff (!resetn)
    (running_reg && both_low) |=> (sel_reg == clock_generation_pkg::SRC_CRYSTAL);
  endproperty
  a_no_backup_when_running: assert property (p_no_backup_when_running) else $error("backup kept while crystal runs");

  property p_backup_after_reset;
    @(posedge clk_sys)
    !resetn |=> backup_active;
  endproperty
  a_backup_after_reset: assert property (p_backup_after_reset) else $error("crystal selected right after reset");

endmodule

// File: verification/osc_model.sv
`timescale 1ns/1ps
module osc_model #(
  parameter real XTAL_HALF = 517.0,
  parameter real RC_HALF = 663.0
) (
  // crystal control
  input wire logic xtal_run,
  // oscillator pins
  output logic xtal_clock_pin,
  output logic rc_clock_pin
);
  // backup oscillator runs whenever a supply is present
  initial
  begin
    rc_clock_pin = 1'b0;
    forever #(RC_HALF) rc_clock_pin = !rc_clock_pin;
  end
  // a stopped crystal rests low, phase unrelated to clk_sys
  initial
  begin
    xtal_clock_pin = 1'b0;
    forever
    begin
      #(XTAL_HALF);
      xtal_clock_pin = xtal_run && !xtal_clock_pin;
    end
  end
endmodule

// File: verification/test_pmic_clock_generation.sv
`timescale 1ns/1ps
module test_pmic_clock_generation;
  logic clk_sys, resetn, coin_cell_power_on_reset_n, xtal_run;
  clock_generation_pkg::reg_req_type reg_req;
  logic [7:0] reg_rdata, pll_feedback_ratio;
  logic [2:0] feedback_ratio_select;
  logic [1:0] slow_clock_drive_strength, audio_clock_drive_strength;
  logic reg_rvalid, xtal_clock_pin, rc_clock_pin, startup_driver_enable, block_clock_request;
  logic companion_rail, factory_test_select_pin, pll_enable, sixteen_meg_output_enable;
  logic slow_clock_output, slow_clock_output_enable, backup_source_active, second_tick;
  logic audio_clock_output_enable, thermal_protection_enable, fuse_program_block;
  logic [7:0] exp_q[$];
  logic [31:0] rnd;
  logic [7:0] v;
  int mismatches, cmp_count, high_run, low_run, stuck, seen_high;

  pmic_clock_generation #(.LOSS_CYCLES(64), .GOOD_EDGES(4)) pmic_clock_generation_i (
    .clk_sys(clk_sys), .resetn(resetn), .coin_cell_power_on_reset_n(coin_cell_power_on_reset_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .xtal_clock_pin(xtal_clock_pin), .rc_clock_pin(rc_clock_pin),
    .startup_driver_enable(startup_driver_enable), .block_clock_request(block_clock_request),
    .companion_rail(companion_rail), .factory_test_select_pin(factory_test_select_pin),
    .feedback_ratio_select(feedback_ratio_select), .pll_feedback_ratio(pll_feedback_ratio),
    .pll_enable(pll_enable), .sixteen_meg_output_enable(sixteen_meg_output_enable),
    .slow_clock_output(slow_clock_output), .slow_clock_output_enable(slow_clock_output_enable),
    .slow_clock_drive_strength(slow_clock_drive_strength), .backup_source_active(backup_source_active),
    .second_tick(second_tick), .audio_clock_output_enable(audio_clock_output_enable),
    .audio_clock_drive_strength(audio_clock_drive_strength),
    .thermal_protection_enable(thermal_protection_enable), .fuse_program_block(fuse_program_block)
  );

  osc_model osc_model_i (
    .xtal_run(xtal_run),
    .xtal_clock_pin(xtal_clock_pin),
    .rc_clock_pin(rc_clock_pin)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // one-cycle request, released at the next falling edge
  task automatic access(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk_sys);
    reg_req = '0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    access(1'b0, a, 8'h00);
  endtask

  task automatic wait_backup(input logic b);
    int n;
    n = 0;
    while (backup_source_active !== b && n < 600)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 600)
    begin
      mismatches++;
      test_done();
    end
  endtask

  // read results are compared as they appear
  always @(negedge clk_sys)
  begin
    if (reg_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(16'hffff, 16'h0000);
      else
        check({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
    end
  end

  // selected clock must never show a short high pulse; runs cut by a reset are skipped
  always @(negedge clk_sys)
  begin
    if (resetn !== 1'b1)
    begin
      high_run = 0;
      low_run = 0;
    end
    else if (slow_clock_output === 1'b1)
      high_run++;
    else
    begin
      if (high_run > 0 && low_run >= 2)
        check(16'(high_run >= 8), 16'h0001);
      if (high_run > 0)
        low_run = 0;
      low_run++;
      high_run = 0;
    end
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = !clk_sys;
  end

  initial
  begin
    #5000000;
    mismatches++;
    test_done();
  end

  initial
  begin
    reg_req = '0;
    resetn = 1'b0;
    coin_cell_power_on_reset_n = 1'b0;
    xtal_run = 1'b0;
    startup_driver_enable = 1'b1;
    block_clock_request = 1'b0;
    companion_rail = 1'b0;
    factory_test_select_pin = 1'b0;
    rnd = 32'h9db368a9;
    settle(10);
    resetn = 1'b1;
    coin_cell_power_on_reset_n = 1'b1;
    settle(4);
    check(pll_feedback_ratio, 16'h007c);
    check(feedback_ratio_select, 16'h0003);
    check({sixteen_meg_output_enable, pll_enable}, 16'h0003);
    check({audio_clock_drive_strength, slow_clock_drive_strength}, 16'h0004);
    check(backup_source_active, 16'h0001);
    check({fuse_program_block, thermal_protection_enable}, 16'h0003);
    check(slow_clock_output_enable, 16'h0001);
    rd(9'h1e4, 8'h1b);
    rd(9'h1c0, 8'h04);
    rd(9'h1e6, 8'h00);
    rd(9'h1ff, 8'h00);
    rd(9'h1e5, 8'h02);
    $display("test reset values done");

    factory_test_select_pin = 1'b1;
    settle(5);
    check(thermal_protection_enable, 16'h0000);
    check(fuse_program_block, 16'h0001);
    rd(9'h1e5, 8'h06);
    factory_test_select_pin = 1'b0;
    settle(5);
    check(thermal_protection_enable, 16'h0001);
    $display("test mode done");

    access(1'b1, 9'h1e5, 8'h01);
    settle(3);
    check(slow_clock_output_enable, 16'h0000);
    resetn = 1'b0;
    settle(4);
    resetn = 1'b1;
    settle(3);
    check(slow_clock_output_enable, 16'h0000);
    rd(9'h1e5, 8'h03);
    coin_cell_power_on_reset_n = 1'b0;
    settle(4);
    coin_cell_power_on_reset_n = 1'b1;
    settle(4);
    check(slow_clock_output_enable, 16'h0001);
    startup_driver_enable = 1'b0;
    settle(2);
    check(slow_clock_output_enable, 16'h0000);
    startup_driver_enable = 1'b1;
    $display("test slow driver done");

    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      v = {rnd[7:5], i[1], i[0], i[2:0]};
      block_clock_request = i[2];
      access(1'b1, 9'h1e4, v);
      settle(3);
      check(pll_feedback_ratio, 16'h0070 + 16'(4 * i));
      check(feedback_ratio_select, 16'(i));
      check(sixteen_meg_output_enable, 16'(i[0]));
      check(pll_enable, 16'(i[0] | i[1] | i[2]));
      rd(9'h1e4, v & 8'h1f);
      rnd = lfsr(rnd);
      access(1'b1, 9'h1c0, rnd[7:0]);
      settle(3);
      check(slow_clock_drive_strength, 16'(rnd[1:0]));
      check(audio_clock_drive_strength, 16'(rnd[3:2]));
      rd(9'h1c0, rnd[7:0]);
    end
    block_clock_request = 1'b0;
    $display("test loop control and drive done");

    companion_rail = 1'b1;
    settle(5);
    check(audio_clock_output_enable, 16'h0001);
    companion_rail = 1'b0;
    settle(5);
    check(audio_clock_output_enable, 16'h0000);
    rnd = lfsr(rnd);
    access(1'b1, 9'h1e6, rnd[7:0]);
    rd(9'h1e6, rnd[7:0]);
    $display("test audio and calibration done");

    xtal_run = 1'b1;
    wait_backup(1'b0);
    check(backup_source_active, 16'h0000);
    rd(9'h1e5, 8'h00);
    stuck = 0;
    seen_high = 0;
    repeat (200)
    begin
      @(negedge clk_sys);
      if (backup_source_active !== 1'b0)
        stuck++;
      if (slow_clock_output === 1'b1)
        seen_high++;
    end
    check(16'(stuck), 16'h0000);
    check(16'(seen_high > 50 && seen_high < 150), 16'h0001);
    xtal_run = 1'b0;
    wait_backup(1'b1);
    rd(9'h1e5, 8'h02);
    settle(100);
    check(second_tick, 16'h0000);
    $display("test source switch done");
    test_done();
  end
endmodule
